// ===== gpc_pin_model.sv
// gpc pin side model: board drivers and floating pins
`timescale 1ns/100ps
module gpc_pin_model (
    input wire logic clk_in,
    input wire logic [7:0] out_g_in,
    input wire logic [7:0] oe_g_in,
    input wire logic [3:0] out_h_in,
    input wire logic [3:0] oe_h_in,
    input wire logic [7:0] ext_g_in,
    input wire logic ext_en_in,
    output logic [7:0] pin_g_out,
    output logic [3:0] pin_h_out
);
    logic [7:0] flip_reg = 8'h55;
    // undriven lines wander every cycle
    always @(posedge clk_in) begin
        flip_reg <= ~flip_reg;
    end
    // pin level: device driver first, else board (port g only), else floating
    assign pin_g_out = (oe_g_in & out_g_in) | (~oe_g_in & (ext_en_in ? ext_g_in : flip_reg));
    assign pin_h_out = (oe_h_in & out_h_in) | (~oe_h_in & flip_reg[3:0]);
endmodule : gpc_pin_model

// ===== gpc_pkg.sv
// gpc types: register bank arrays and the module state record
package gpc_pkg;

    typedef logic [7:0] gpc_byte_t;
    typedef logic [3:0] gpc_nib_t;
    // six 8-bit ports, index 0 is the lowest port of the bank
    typedef logic [5:0][7:0] gpc_bank_t;

    typedef struct packed {
        gpc_bank_t wpu;      // pull-up enables, ports a..f
        gpc_bank_t ansel;    // analog selects, ports a,b,d,e,f,g
        gpc_byte_t lat_g;
        gpc_nib_t lat_h;
        gpc_byte_t drvg;     // driver disable, 1 = off
        gpc_nib_t drvh;
        gpc_byte_t s1_g;
        gpc_byte_t s2_g;
        gpc_byte_t s3_g;
        gpc_byte_t filt_g;
        gpc_nib_t s1_h;
        gpc_nib_t s2_h;
        gpc_nib_t s3_h;
        gpc_nib_t filt_h;
        gpc_byte_t rdata;
        gpc_byte_t pin_g;
        gpc_byte_t oe_g;
        gpc_nib_t pin_h;
        gpc_nib_t oe_h;
        gpc_bank_t pull;
        gpc_bank_t din_en;
    } gpc_state_t;

endpackage : gpc_pkg

// ===== gpc_port_cfg.sv
// gpc port latch, analog select and pull-up configuration block
`timescale 1ns/100ps
`include "gpc_regs.svh"

// Summary of operation
// - pin register write equals latch write
// - latch read returns stored latch bits
// - port g bits 7:6 survive brown-out
// - port g bits 4:0 survive other resets
// - port h latch is four bits only
// - analog select disables digital input buffer
// - analog selects reset to one
// - port g bit 5 has no analog select
// - pull-up bit one enables weak pull-up
// - pull-up registers reset to zero
// - driver disable one turns output off
module gpc_port_cfg
    import gpc_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic BROWN_OUT_RST_IN,
    input wire logic SOFT_RST_IN,
    input wire logic [`GPC_ADDR_W-1:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    input wire logic [7:0] PIN_G_IN,
    input wire logic [3:0] PIN_H_IN,
    output logic [7:0] PIN_G_OUT,
    output logic [7:0] PIN_G_OE_OUT,
    output logic [3:0] PIN_H_OUT,
    output logic [3:0] PIN_H_OE_OUT,
    output gpc_bank_t PULLUP_EN_OUT,
    output gpc_bank_t DIG_IN_EN_OUT
);

    gpc_state_t r_reg;
    gpc_state_t r_next;
    logic any_rst;

    assign any_rst = BROWN_OUT_RST_IN | SOFT_RST_IN;

    // ****************************************************
    // next-state logic
    // ****************************************************

    // sync, register access, output staging, resets
    always_comb begin
        r_next = r_reg;
        // three-stage pin sync, accept when stages 2 and 3 agree
        r_next.s1_g = PIN_G_IN;
        r_next.s2_g = r_reg.s1_g;
        r_next.s3_g = r_reg.s2_g;
        r_next.s1_h = PIN_H_IN;
        r_next.s2_h = r_reg.s1_h;
        r_next.s3_h = r_reg.s2_h;
        for (int i = 0; i < 8; i++) begin
            if (r_reg.s2_g[i] == r_reg.s3_g[i]) begin
                r_next.filt_g[i] = r_reg.s3_g[i];
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (r_reg.s2_h[i] == r_reg.s3_h[i]) begin
                r_next.filt_h[i] = r_reg.s3_h[i];
            end
        end
        // register writes
        if (WR_IN) begin
            case (ADDR_IN)
                `GPC_PU_A_ADDR: r_next.wpu[0] = WDATA_IN;
                `GPC_PU_B_ADDR: r_next.wpu[1] = WDATA_IN;
                `GPC_PU_C_ADDR: r_next.wpu[2] = WDATA_IN;
                `GPC_PU_D_ADDR: r_next.wpu[3] = WDATA_IN;
                `GPC_PU_E_ADDR: r_next.wpu[4] = WDATA_IN;
                `GPC_PU_F_ADDR: r_next.wpu[5] = WDATA_IN;
                `GPC_AN_A_ADDR: r_next.ansel[0] = WDATA_IN;
                `GPC_AN_B_ADDR: r_next.ansel[1] = WDATA_IN;
                `GPC_AN_D_ADDR: r_next.ansel[2] = WDATA_IN;
                `GPC_AN_E_ADDR: r_next.ansel[3] = WDATA_IN;
                `GPC_AN_F_ADDR: r_next.ansel[4] = WDATA_IN;
                `GPC_AN_G_ADDR: r_next.ansel[5] = WDATA_IN & `GPC_G_MASK;
                `GPC_LAT_G_ADDR, `GPC_PING_ADDR: r_next.lat_g = WDATA_IN & `GPC_G_MASK;
                `GPC_LAT_H_ADDR, `GPC_PINH_ADDR: r_next.lat_h = WDATA_IN[3:0];
                `GPC_DRVG_ADDR: r_next.drvg = WDATA_IN | ~`GPC_G_MASK;
                `GPC_DRVH_ADDR: r_next.drvh = WDATA_IN[3:0];
                default: begin
                end
            endcase
        end
        // read data, valid in the cycle after the strobe
        r_next.rdata = 8'h00;
        if (RD_IN) begin
            case (ADDR_IN)
                `GPC_PU_A_ADDR: r_next.rdata = r_reg.wpu[0];
                `GPC_PU_B_ADDR: r_next.rdata = r_reg.wpu[1];
                `GPC_PU_C_ADDR: r_next.rdata = r_reg.wpu[2];
                `GPC_PU_D_ADDR: r_next.rdata = r_reg.wpu[3];
                `GPC_PU_E_ADDR: r_next.rdata = r_reg.wpu[4];
                `GPC_PU_F_ADDR: r_next.rdata = r_reg.wpu[5];
                `GPC_AN_A_ADDR: r_next.rdata = r_reg.ansel[0];
                `GPC_AN_B_ADDR: r_next.rdata = r_reg.ansel[1];
                `GPC_AN_D_ADDR: r_next.rdata = r_reg.ansel[2];
                `GPC_AN_E_ADDR: r_next.rdata = r_reg.ansel[3];
                `GPC_AN_F_ADDR: r_next.rdata = r_reg.ansel[4];
                `GPC_AN_G_ADDR: r_next.rdata = r_reg.ansel[5];
                `GPC_LAT_G_ADDR: r_next.rdata = r_reg.lat_g;
                `GPC_LAT_H_ADDR: r_next.rdata = {4'h0, r_reg.lat_h};
                `GPC_DRVG_ADDR: r_next.rdata = r_reg.drvg;
                `GPC_DRVH_ADDR: r_next.rdata = {4'h0, r_reg.drvh};
                `GPC_PING_ADDR: r_next.rdata = r_reg.filt_g & ~r_reg.ansel[5];
                `GPC_PINH_ADDR: r_next.rdata = {4'h0, r_reg.filt_h};
                default: r_next.rdata = 8'h00;
            endcase
        end
        // pin-facing outputs from stored configuration
        r_next.pin_g = r_reg.lat_g;
        r_next.oe_g = ~r_reg.drvg & `GPC_G_MASK;
        r_next.pin_h = r_reg.lat_h;
        r_next.oe_h = ~r_reg.drvh;
        r_next.pull = r_reg.wpu;
        for (int i = 0; i < 6; i++) begin
            r_next.din_en[i] = ~r_reg.ansel[i];
        end
        // resets: power-on > brown-out > other sources
        if (RST_IN || any_rst) begin
            for (int i = 0; i < 5; i++) begin
                r_next.wpu[i] = `GPC_WPU_RST;
                r_next.ansel[i] = `GPC_ANSEL_RST;
            end
            r_next.wpu[5] = `GPC_WPU_RST;
            r_next.ansel[5] = `GPC_ANSEL_G_RST;
            r_next.drvg = `GPC_DRVG_RST;
            r_next.drvh = `GPC_DRVH_RST;
            // other resets leave both latches alone
            if (RST_IN || BROWN_OUT_RST_IN) begin
                r_next.lat_g = r_reg.lat_g & ~`GPC_G_LO_MASK;
                r_next.lat_h = 4'h0;
            end else begin
                r_next.lat_g = r_reg.lat_g;
                r_next.lat_h = r_reg.lat_h;
            end
            if (RST_IN) begin
                r_next.lat_g = `GPC_LAT_POR;
                r_next.s1_g = 8'h00;
                r_next.s2_g = 8'h00;
                r_next.s3_g = 8'h00;
                r_next.filt_g = 8'h00;
                r_next.s1_h = 4'h0;
                r_next.s2_h = 4'h0;
                r_next.s3_h = 4'h0;
                r_next.filt_h = 4'h0;
                r_next.rdata = 8'h00;
                r_next.pin_g = 8'h00;
                r_next.oe_g = 8'h00;
                r_next.pin_h = 4'h0;
                r_next.oe_h = 4'h0;
                r_next.pull = '0;
                r_next.din_en = '0;
            end
        end
    end

    // ****************************************************
    // state register and outputs
    // ****************************************************

    // single state register
    always_ff @(posedge CLK_IN) begin
        r_reg <= r_next;
    end

    // outputs straight from flops
    assign RDATA_OUT = r_reg.rdata;
    assign PIN_G_OUT = r_reg.pin_g;
    assign PIN_G_OE_OUT = r_reg.oe_g;
    assign PIN_H_OUT = r_reg.pin_h;
    assign PIN_H_OE_OUT = r_reg.oe_h;
    assign PULLUP_EN_OUT = r_reg.pull;
    assign DIG_IN_EN_OUT = r_reg.din_en;

    // ****************************************************
    // assertions
    // ****************************************************

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    property p_pin_write_latch;
        WR_IN && !any_rst && ADDR_IN == `GPC_PING_ADDR |=> ##1 PIN_G_OUT == ($past(WDATA_IN, 2) & `GPC_G_MASK);
    endproperty
    a_pin_write_latch: assert property (p_pin_write_latch) else $error("pin register write missed latch");

    property p_latch_read;
        RD_IN && ADDR_IN == `GPC_LAT_G_ADDR |=> RDATA_OUT == $past(r_reg.lat_g);
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("latch read not stored value");

    property p_bor_keep_hi;
        BROWN_OUT_RST_IN |=> r_reg.lat_g[7:6] == $past(r_reg.lat_g[7:6]) && r_reg.lat_g[4:0] == 5'h00;
    endproperty
    a_bor_keep_hi: assert property (p_bor_keep_hi) else $error("brown-out latch g wrong");

    property p_soft_keep;
        SOFT_RST_IN && !BROWN_OUT_RST_IN |=> r_reg.lat_g == $past(r_reg.lat_g) && r_reg.lat_h == $past(r_reg.lat_h);
    endproperty
    a_soft_keep: assert property (p_soft_keep) else $error("other reset touched latches");

    property p_lat_h_narrow;
        RD_IN && ADDR_IN == `GPC_LAT_H_ADDR |=> RDATA_OUT[7:4] == 4'h0;
    endproperty
    a_lat_h_narrow: assert property (p_lat_h_narrow) else $error("latch h upper bits nonzero");

    property p_din_en;
        !$past(RST_IN) |-> DIG_IN_EN_OUT == ~$past(r_reg.ansel);
    endproperty
    a_din_en: assert property (p_din_en) else $error("input buffer enable mismatch");

    property p_ansel_rst;
        any_rst |=> r_reg.ansel[0] == `GPC_ANSEL_RST ##1 DIG_IN_EN_OUT[3] == 8'h00;
    endproperty
    a_ansel_rst: assert property (p_ansel_rst) else $error("analog select reset wrong");

    property p_ansel_g_bit5;
        RD_IN && ADDR_IN == `GPC_AN_G_ADDR |=> RDATA_OUT[5] == 1'b0;
    endproperty
    a_ansel_g_bit5: assert property (p_ansel_g_bit5) else $error("analog select g bit 5 set");

    property p_pullup;
        WR_IN && !any_rst && ADDR_IN == `GPC_PU_C_ADDR |=> ##1 PULLUP_EN_OUT[2] == $past(WDATA_IN, 2);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up enable not applied");

    property p_wpu_rst;
        SOFT_RST_IN |=> r_reg.wpu == '0;
    endproperty
    a_wpu_rst: assert property (p_wpu_rst) else $error("pull-up reset not zero");

    property p_driver;
        !$past(RST_IN) |-> PIN_G_OE_OUT == (~$past(r_reg.drvg) & `GPC_G_MASK);
    endproperty
    a_driver: assert property (p_driver) else $error("driver enable mismatch");

    property p_unmapped;
        RD_IN && ADDR_IN == `GPC_UNMAPPED_ADDR |=> RDATA_OUT == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

    property p_analog_read;
        RD_IN && ADDR_IN == `GPC_PING_ADDR |=> (RDATA_OUT & $past(r_reg.ansel[5])) == 8'h00;
    endproperty
    a_analog_read: assert property (p_analog_read) else $error("analog pin read as one");

    c_latch_write: cover property (WR_IN && ADDR_IN == `GPC_LAT_G_ADDR ##1 RD_IN && ADDR_IN == `GPC_LAT_G_ADDR);
    c_brown_out: cover property (BROWN_OUT_RST_IN ##1 !BROWN_OUT_RST_IN);
    c_pin_read: cover property (RD_IN && ADDR_IN == `GPC_PING_ADDR && r_reg.ansel[5] != 8'h00);

endmodule : gpc_port_cfg

// ===== gpc_port_cfg_test.sv
// gpc port configuration self-checking testbench
`timescale 1ns/100ps
`include "gpc_regs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module gpc_port_cfg_test;
    import gpc_pkg::*;
    logic CLK_IN, RST_IN, BROWN_OUT_RST_IN, SOFT_RST_IN, WR_IN, RD_IN, ext_en;
    logic [11:0] ADDR_IN;
    gpc_byte_t WDATA_IN, RDATA_OUT, pin_g, pin_g_out, pin_g_oe, ext_g;
    gpc_nib_t pin_h, pin_h_out, pin_h_oe;
    gpc_bank_t pullup_en, dig_in_en;
    int error_cnt = 0;
    int checks_done = 0;
    logic [11:0] wpu_a [6] = '{`GPC_PU_A_ADDR, `GPC_PU_B_ADDR, `GPC_PU_C_ADDR, `GPC_PU_D_ADDR,
        `GPC_PU_E_ADDR, `GPC_PU_F_ADDR};
    logic [11:0] ans_a [6] = '{`GPC_AN_A_ADDR, `GPC_AN_B_ADDR, `GPC_AN_D_ADDR, `GPC_AN_E_ADDR,
        `GPC_AN_F_ADDR, `GPC_AN_G_ADDR};
    // reference model of the register bank
    gpc_byte_t m_wpu [6];
    gpc_byte_t m_ans [6];
    gpc_byte_t m_lg;
    gpc_nib_t m_lh;

    gpc_port_cfg u_gpc_port_cfg (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .BROWN_OUT_RST_IN(BROWN_OUT_RST_IN),
        .SOFT_RST_IN(SOFT_RST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
        .RDATA_OUT(RDATA_OUT), .PIN_G_IN(pin_g), .PIN_H_IN(pin_h), .PIN_G_OUT(pin_g_out),
        .PIN_G_OE_OUT(pin_g_oe), .PIN_H_OUT(pin_h_out), .PIN_H_OE_OUT(pin_h_oe),
        .PULLUP_EN_OUT(pullup_en), .DIG_IN_EN_OUT(dig_in_en));
    gpc_pin_model u_gpc_pin_model (.clk_in(CLK_IN), .out_g_in(pin_g_out), .oe_g_in(pin_g_oe),
        .out_h_in(pin_h_out), .oe_h_in(pin_h_oe), .ext_g_in(ext_g), .ext_en_in(ext_en),
        .pin_g_out(pin_g), .pin_h_out(pin_h));

    // bus write: one strobe cycle
    task automatic wr(input logic [11:0] a, input gpc_byte_t d);
        @(posedge CLK_IN);
        ADDR_IN <= a;
        WDATA_IN <= d;
        WR_IN <= 1'b1;
        @(posedge CLK_IN);
        WR_IN <= 1'b0;
    endtask : wr
    // bus read and compare in the answer cycle
    task automatic rchk(input logic [11:0] a, input gpc_byte_t e);
        @(posedge CLK_IN);
        ADDR_IN <= a;
        RD_IN <= 1'b1;
        @(posedge CLK_IN);
        RD_IN <= 1'b0;
        #1;
        `CHK(RDATA_OUT, e)
    endtask : rchk
    // configuration reset in the model
    task automatic mrst();
        foreach (m_wpu[i]) begin
            m_wpu[i] = 8'h00;
            m_ans[i] = (i == 5) ? 8'hdf : 8'hff;
        end
    endtask : mrst
    task automatic cfgchk();
        foreach (wpu_a[i]) begin
            rchk(wpu_a[i], m_wpu[i]);
            rchk(ans_a[i], m_ans[i]);
        end
    endtask : cfgchk
    // outputs settle one cycle after the registers
    task automatic outchk();
        repeat (2) @(posedge CLK_IN);
        #1;
        foreach (m_wpu[i]) begin
            `CHK(pullup_en[i], m_wpu[i])
            `CHK(dig_in_en[i], ~m_ans[i])
        end
        `CHK(pin_g_out, m_lg)
        `CHK(pin_h_out, m_lh)
        `CHK(pin_g_oe, 8'h00)
        `CHK(pin_h_oe, 4'h0)
    endtask : outchk
    task automatic pulse(input bit brown);
        @(posedge CLK_IN);
        if (brown) BROWN_OUT_RST_IN <= 1'b1; else SOFT_RST_IN <= 1'b1;
        @(posedge CLK_IN);
        BROWN_OUT_RST_IN <= 1'b0;
        SOFT_RST_IN <= 1'b0;
        mrst();
    endtask : pulse
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    initial begin
        CLK_IN = 1'b0;
        forever #2 CLK_IN = ~CLK_IN;
    end
    // watchdog
    initial begin
        #80000;
        error_cnt++;
        conclude();
    end
    initial begin
        gpc_byte_t d;
        {BROWN_OUT_RST_IN, SOFT_RST_IN, WR_IN, RD_IN, ext_en, ADDR_IN, WDATA_IN, ext_g} = '0;
        RST_IN = 1'b1;
        repeat (4) @(posedge CLK_IN);
        RST_IN <= 1'b0;
        void'($urandom(18052));
        mrst();
        m_lg = 8'h00;
        m_lh = 4'h0;
        cfgchk();
        outchk();
        $display("test reset values done");
        repeat (3) foreach (wpu_a[i]) begin
            d = $urandom;
            wr(wpu_a[i], d);
            m_wpu[i] = d;
            d = $urandom;
            wr(ans_a[i], d);
            m_ans[i] = d & ((i == 5) ? 8'hdf : 8'hff);
        end
        cfgchk();
        outchk();
        $display("test config writes done");
        wr(`GPC_LAT_G_ADDR, 8'hff);
        m_lg = 8'hdf;
        rchk(`GPC_LAT_G_ADDR, m_lg);
        wr(`GPC_PING_ADDR, 8'h5a);
        m_lg = 8'h5a;
        rchk(`GPC_LAT_G_ADDR, m_lg);
        wr(`GPC_LAT_H_ADDR, 8'hff);
        m_lh = 4'hf;
        rchk(`GPC_LAT_H_ADDR, {4'h0, m_lh});
        wr(`GPC_PINH_ADDR, 8'h06);
        m_lh = 4'h6;
        rchk(`GPC_LAT_H_ADDR, {4'h0, m_lh});
        outchk();
        ext_g <= ~m_lg & 8'hdf;
        ext_en <= 1'b1;
        repeat (6) @(posedge CLK_IN);
        rchk(`GPC_LAT_G_ADDR, m_lg);
        rchk(`GPC_PING_ADDR, ext_g & ~m_ans[5]);
        wr(`GPC_DRVG_ADDR, 8'h00);
        repeat (6) @(posedge CLK_IN);
        `CHK(pin_g_oe, 8'hdf)
        rchk(`GPC_PING_ADDR, m_lg & ~m_ans[5]);
        // port h drivers on: pins follow the latch
        wr(`GPC_DRVH_ADDR, 8'h00);
        repeat (6) @(posedge CLK_IN);
        `CHK(pin_h_oe, 4'hf)
        rchk(`GPC_PINH_ADDR, {4'h0, m_lh});
        $display("test latch and pins done");
        pulse(1'b0);
        cfgchk();
        rchk(`GPC_LAT_G_ADDR, m_lg);
        rchk(`GPC_LAT_H_ADDR, {4'h0, m_lh});
        pulse(1'b1);
        m_lg = m_lg & 8'hc0;
        m_lh = 4'h0;
        rchk(`GPC_LAT_G_ADDR, m_lg);
        rchk(`GPC_LAT_H_ADDR, {4'h0, m_lh});
        wr(`GPC_UNMAPPED_ADDR, 8'hff);
        rchk(`GPC_UNMAPPED_ADDR, 8'h00);
        $display("test resets and unmapped done");
        conclude();
    end
endmodule : gpc_port_cfg_test

// ===== gpc_regs.svh
// gpc register offsets, field masks and reset values
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

`define GPC_ADDR_W 12
`define GPC_PU_A_ADDR 12'he91
`define GPC_AN_A_ADDR 12'he92
`define GPC_PU_B_ADDR 12'he99
`define GPC_AN_B_ADDR 12'he9a
`define GPC_PU_C_ADDR 12'hea1
`define GPC_PU_D_ADDR 12'hea6
`define GPC_AN_D_ADDR 12'hea7
`define GPC_PU_E_ADDR 12'heae
`define GPC_AN_E_ADDR 12'heaf
`define GPC_PU_F_ADDR 12'heb3
`define GPC_AN_F_ADDR 12'heb4
`define GPC_AN_G_ADDR 12'hebc
`define GPC_LAT_G_ADDR 12'hf7f
`define GPC_LAT_H_ADDR 12'hf80
`define GPC_DRVG_ADDR 12'hf87
`define GPC_DRVH_ADDR 12'hf88
`define GPC_PING_ADDR 12'hf8d
`define GPC_PINH_ADDR 12'hf8e
`define GPC_UNMAPPED_ADDR 12'h000

`define GPC_G_MASK 8'hdf
`define GPC_G_HI_MASK 8'hc0
`define GPC_G_LO_MASK 8'h1f
`define GPC_H_MASK 4'hf
`define GPC_ANSEL_RST 8'hff
`define GPC_ANSEL_G_RST 8'hdf
`define GPC_WPU_RST 8'h00
`define GPC_DRVG_RST 8'hff
`define GPC_DRVH_RST 4'hf
`define GPC_LAT_POR 8'h00

`endif
